// ==== hw/tpt_translator.sv ====
// tpt_translator: two-level linear to physical address translator, three levels with address extension on.
// assumes an APB master and a memory port that answers each read with mem_ack.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module tpt_translator #(
  parameter bit WIDE_LARGE = 1'b1,
  parameter int SMALL_IW = 4,
  parameter int LARGE_IW = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tpt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic [tpt_pkg::PA_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  output logic page_fault_exception
);
  import tpt_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_PRIMARY, OFS_DIRBASE, OFS_EXT, OFS_LIN: reg_hit = 1'b1;
      OFS_PHYS_LO, OFS_PHYS_HI, OFS_STATUS, OFS_FLUSH: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] primary_ctrl_reg_r, primary_ctrl_reg_nxt;
  logic [31:0] directory_base_ctrl_r, directory_base_ctrl_nxt;
  logic [31:0] extension_ctrl_reg_r, extension_ctrl_reg_nxt;
  logic [31:0] lin_r, lin_nxt;
  logic [PA_W-1:0] phys_r, phys_nxt;
  logic done_r, done_nxt;
  logic fault_r, fault_nxt;
  logic hit_r, hit_nxt;
  logic large_r, large_nxt;
  logic pf_r, pf_nxt;
  logic mem_req_r, mem_req_nxt;
  logic [PA_W-1:0] mem_addr_r, mem_addr_nxt;
  logic [63:0] ent_r, ent_nxt;
  tpt_state_t st_r, st_nxt;

  logic acc, wr_go, translate_enable, large_page_enable, address_extension_enable;
  logic [63:0] rd_ent;
  logic entry_size_flag, go_large;
  logic [PA_W-1:0] walk_addr;
  logic [31:0] rd_mux;

  tpt_tlb_if #(.KW(SMALL_KW), .DW(SMALL_DW)) sm ();
  tpt_tlb_if #(.KW(LARGE_KW), .DW(LARGE_DW)) lg ();

  // separate caches per page size
  tpt_tlb #(.KW(SMALL_KW), .DW(SMALL_DW), .IW(SMALL_IW)) u_small (
    .pclk(pclk),
    .presetn(presetn),
    .lk(sm.cache)
  );
  tpt_tlb #(.KW(LARGE_KW), .DW(LARGE_DW), .IW(LARGE_IW)) u_large (
    .pclk(pclk),
    .presetn(presetn),
    .lk(lg.cache)
  );
  tpt_walk_addr u_addr (
    .tgt(st_nxt),
    .ext_en(address_extension_enable),
    .dir_base(directory_base_ctrl_r),
    .lin(lin_r),
    .ent(ent_nxt),
    .addr(walk_addr)
  );

  assign acc = psel && penable;
  assign wr_go = acc && pready_r && pwrite;
  assign translate_enable = primary_ctrl_reg_r[TRANSLATE_EN_BIT];
  assign large_page_enable = extension_ctrl_reg_r[LARGE_EN_BIT];
  assign address_extension_enable = extension_ctrl_reg_r[EXT_EN_BIT];
  // without extension only the low word of an entry is meaningful
  assign rd_ent = address_extension_enable ? mem_rdata : {32'h0000_0000, mem_rdata[31:0]};
  assign entry_size_flag = rd_ent[SIZE_FLAG_BIT];
  // size flag ignored unless one of the large modes is on
  assign go_large = entry_size_flag && (address_extension_enable || large_page_enable);
  assign sm.key = lin_r[31:12];
  assign lg.key = lin_r[31:21];

  always_comb begin
    case (paddr)
      OFS_PRIMARY: rd_mux = primary_ctrl_reg_r;
      OFS_DIRBASE: rd_mux = directory_base_ctrl_r;
      OFS_EXT: rd_mux = extension_ctrl_reg_r;
      OFS_LIN: rd_mux = lin_r;
      OFS_PHYS_LO: rd_mux = phys_r[31:0];
      OFS_PHYS_HI: rd_mux = {28'h000_0000, phys_r[35:32]};
      OFS_STATUS: rd_mux = {27'h000_0000, large_r, hit_r, fault_r, done_r, st_r != ST_IDLE};
      default: rd_mux = RST_REG;
    endcase
  end

  // ----------------------------------------
  // bus and walk next state
  // ----------------------------------------
  always_comb begin
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    primary_ctrl_reg_nxt = primary_ctrl_reg_r;
    directory_base_ctrl_nxt = directory_base_ctrl_r;
    extension_ctrl_reg_nxt = extension_ctrl_reg_r;
    lin_nxt = lin_r;
    phys_nxt = phys_r;
    done_nxt = done_r;
    fault_nxt = fault_r;
    hit_nxt = hit_r;
    large_nxt = large_r;
    pf_nxt = 1'b0;
    mem_req_nxt = mem_req_r;
    mem_addr_nxt = mem_addr_r;
    ent_nxt = ent_r;
    st_nxt = st_r;
    sm.fill = 1'b0;
    sm.fill_data = rd_ent[35:12];
    lg.fill = 1'b0;
    lg.fill_data = '0;
    sm.flush = 1'b0;
    // one wait cycle: ready is a flop raised in the first access cycle
    if (acc && !pready_r) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !reg_hit(paddr);
      if (!pwrite) begin
        prdata_nxt = rd_mux;
      end
    end
    if (wr_go) begin
      case (paddr)
        OFS_PRIMARY: primary_ctrl_reg_nxt = pwdata;
        OFS_DIRBASE: begin
          // whole word kept: no present flag in this register
          directory_base_ctrl_nxt = pwdata;
          sm.flush = 1'b1;
        end
        OFS_EXT: begin
          extension_ctrl_reg_nxt = pwdata;
          sm.flush = 1'b1;
        end
        OFS_STATUS: begin
          if (pwdata[ST_DONE_BIT]) begin
            done_nxt = 1'b0;
          end
          if (pwdata[ST_FAULT_BIT]) begin
            fault_nxt = 1'b0;
          end
        end
        OFS_FLUSH: sm.flush = 1'b1;
        OFS_LIN: begin
          // a new address while a walk runs is dropped
          if (st_r == ST_IDLE) begin
            lin_nxt = pwdata;
            done_nxt = 1'b0;
            fault_nxt = 1'b0;
            hit_nxt = 1'b0;
            large_nxt = 1'b0;
            if (!translate_enable) begin
              phys_nxt = {4'h0, pwdata};
              done_nxt = 1'b1;
            end else begin
              st_nxt = ST_LOOK;
            end
          end
        end
        default: ;
      endcase
    end
    // hardware set lands after software clear, so a set always wins
    case (st_r)
      ST_LOOK: begin
        if (lg.hit) begin
          phys_nxt = {lg.data, lin_r[20:0]};
          {done_nxt, hit_nxt, large_nxt} = 3'b111;
          st_nxt = ST_IDLE;
        end else if (sm.hit) begin
          phys_nxt = {sm.data, lin_r[11:0]};
          {done_nxt, hit_nxt} = 2'b11;
          st_nxt = ST_IDLE;
        end else begin
          st_nxt = address_extension_enable ? ST_PTR : ST_DIR;
          mem_req_nxt = 1'b1;
          mem_addr_nxt = walk_addr;
        end
      end
      ST_PTR: begin
        if (mem_ack) begin
          ent_nxt = mem_rdata;
          if (!mem_rdata[PRESENT_BIT]) begin
            {fault_nxt, pf_nxt, done_nxt, mem_req_nxt} = 4'b1110;
            st_nxt = ST_IDLE;
          end else begin
            st_nxt = ST_DIR;
            mem_addr_nxt = walk_addr;
          end
        end
      end
      ST_DIR: begin
        if (mem_ack) begin
          ent_nxt = rd_ent;
          if (!rd_ent[PRESENT_BIT]) begin
            {fault_nxt, pf_nxt, done_nxt, mem_req_nxt} = 4'b1110;
            st_nxt = ST_IDLE;
          end else if (go_large) begin
            mem_req_nxt = 1'b0;
            {done_nxt, large_nxt} = 2'b11;
            st_nxt = ST_IDLE;
            lg.fill = 1'b1;
            if (address_extension_enable) begin
              lg.fill_data = rd_ent[35:21];
            end else begin
              // 10 base bits; wide feature adds four upper bits
              lg.fill_data = {WIDE_LARGE ? rd_ent[16:13] : 4'h0,
                              rd_ent[31:22], lin_r[21]};
            end
            phys_nxt = {lg.fill_data, lin_r[20:0]};
          end else begin
            // table fetch only after the directory entry is back
            st_nxt = ST_TBL;
            mem_addr_nxt = walk_addr;
          end
        end
      end
      ST_TBL: begin
        if (mem_ack) begin
          mem_req_nxt = 1'b0;
          st_nxt = ST_IDLE;
          done_nxt = 1'b1;
          if (!rd_ent[PRESENT_BIT]) begin
            {fault_nxt, pf_nxt} = 2'b11;
          end else begin
            sm.fill = 1'b1;
            phys_nxt = {rd_ent[35:12], lin_r[11:0]};
          end
        end
      end
      default: ;
    endcase
  end

  assign lg.flush = sm.flush;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= RST_REG;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      primary_ctrl_reg_r <= RST_REG;
      directory_base_ctrl_r <= RST_REG;
      extension_ctrl_reg_r <= RST_REG;
      lin_r <= RST_REG;
      phys_r <= RST_PA;
      done_r <= 1'b0;
      fault_r <= 1'b0;
      hit_r <= 1'b0;
      large_r <= 1'b0;
      pf_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_addr_r <= RST_PA;
      ent_r <= 64'h0000_0000_0000_0000;
      st_r <= ST_IDLE;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      primary_ctrl_reg_r <= primary_ctrl_reg_nxt;
      directory_base_ctrl_r <= directory_base_ctrl_nxt;
      extension_ctrl_reg_r <= extension_ctrl_reg_nxt;
      lin_r <= lin_nxt;
      phys_r <= phys_nxt;
      done_r <= done_nxt;
      fault_r <= fault_nxt;
      hit_r <= hit_nxt;
      large_r <= large_nxt;
      pf_r <= pf_nxt;
      mem_req_r <= mem_req_nxt;
      mem_addr_r <= mem_addr_nxt;
      ent_r <= ent_nxt;
      st_r <= st_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mem_req = mem_req_r;
  assign mem_addr = mem_addr_r;
  assign page_fault_exception = pf_r;
endmodule

// ==== shared/tpt_pkg.sv ====
// tpt_pkg: constants shared by the page translator and its helpers.
// assumes an APB slave with 32-bit data and 36-bit physical memory reads.
package tpt_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_PRIMARY = 8'h00;
  localparam logic [7:0] OFS_DIRBASE = 8'h04;
  localparam logic [7:0] OFS_EXT = 8'h08;
  localparam logic [7:0] OFS_LIN = 8'h0C;
  localparam logic [7:0] OFS_PHYS_LO = 8'h10;
  localparam logic [7:0] OFS_PHYS_HI = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_FLUSH = 8'h1C;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int TRANSLATE_EN_BIT = 31;
  localparam int LARGE_EN_BIT = 4;
  localparam int EXT_EN_BIT = 5;
  localparam int PRESENT_BIT = 0;
  localparam int SIZE_FLAG_BIT = 7;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_FAULT_BIT = 2;
  localparam int ST_HIT_BIT = 3;
  localparam int ST_LARGE_BIT = 4;
  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int PA_W = 36;
  localparam int SMALL_KW = 20;
  localparam int SMALL_DW = 24;
  localparam int LARGE_KW = 11;
  localparam int LARGE_DW = 15;
  localparam logic [31:0] RST_REG = 32'h0000_0000;
  localparam logic [PA_W-1:0] RST_PA = 36'h0_0000_0000;
  // ----------------------------------------
  // walk states, gray along idle-look-ptr-dir-tbl
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOOK = 3'h1,
    ST_PTR = 3'h3,
    ST_DIR = 3'h2,
    ST_TBL = 3'h6
  } tpt_state_t;
endpackage

// ==== shared/tpt_tlb_if.sv ====
// tpt_tlb_if: lookup and fill path between walker and one translation cache.
// assumes key is held stable by the walker for the whole lookup.
`timescale 1ns/1ps
interface tpt_tlb_if #(
  parameter int KW = 20,
  parameter int DW = 24
);
  logic [KW-1:0] key;
  logic hit;
  logic [DW-1:0] data;
  logic fill;
  logic [DW-1:0] fill_data;
  logic flush;
  modport cache (input key, input fill, input fill_data, input flush, output hit, output data);
  modport user (output key, output fill, output fill_data, output flush, input hit, input data);
endinterface

// ==== hw/tpt_tlb.sv ====
// tpt_tlb: direct-mapped translation cache, one per page size.
// assumes fill and flush are single-cycle strobes from the walker.
`timescale 1ns/1ps
module tpt_tlb #(
  parameter int KW = 20,
  parameter int DW = 24,
  parameter int IW = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  tpt_tlb_if.cache lk
);
  import tpt_pkg::*;
  localparam int N = 1 << IW;
  logic [DW-1:0] data_mem [N];
  logic [KW-IW-1:0] tag_mem [N];
  logic [N-1:0] valid_r;
  logic [N-1:0] valid_nxt;
  logic [IW-1:0] idx;

  assign idx = lk.key[IW-1:0];
  // hit only for a valid slot whose tag matches
  assign lk.hit = valid_r[idx] && (tag_mem[idx] == lk.key[KW-1:IW]);
  assign lk.data = data_mem[idx];

  // flush wins over a fill in the same cycle: a walk that fills in the flush cycle is not cached
  for (genvar i = 0; i < N; i++) begin : g_valid
    always_comb begin
      if (lk.flush) begin
        valid_nxt[i] = 1'b0;
      end else if (lk.fill && idx == IW'(i)) begin
        valid_nxt[i] = 1'b1;
      end else begin
        valid_nxt[i] = valid_r[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_r <= '0;
    end else begin
      valid_r <= valid_nxt;
    end
  end

  always_ff @(posedge pclk) begin
    if (lk.fill) begin
      data_mem[idx] <= lk.fill_data;
      tag_mem[idx] <= lk.key[KW-1:IW];
    end
  end
endmodule

// ==== hw/tpt_walk_addr.sv ====
// tpt_walk_addr: memory address of the next table entry to fetch.
// assumes ent holds the entry fetched one level above the target level.
`timescale 1ns/1ps
module tpt_walk_addr (
  input tpt_pkg::tpt_state_t tgt,
  input wire logic ext_en,
  input wire logic [31:0] dir_base,
  input wire logic [31:0] lin,
  input wire logic [63:0] ent,
  output logic [tpt_pkg::PA_W-1:0] addr
);
  import tpt_pkg::*;
  always_comb begin
    case (tgt)
      ST_PTR: addr = {4'h0, dir_base[31:5], lin[31:30], 3'h0};
      ST_DIR: begin
        if (ext_en) begin
          addr = {ent[35:12], lin[29:21], 3'h0};
        end else begin
          addr = {4'h0, dir_base[31:12], lin[31:22], 2'h0};
        end
      end
      ST_TBL: begin
        if (ext_en) begin
          addr = {ent[35:12], lin[20:12], 3'h0};
        end else begin
          addr = {4'h0, ent[31:12], lin[21:12], 2'h0};
        end
      end
      default: addr = RST_PA;
    endcase
  end
endmodule

// ==== testbench/tpt_translator_monitor.sv ====
// tpt_translator_monitor: port-level assertions for the page translator.
// assumes the single pclk domain and the active low presetn of the top.
`timescale 1ns/1ps
module tpt_translator_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_req,
  input wire logic [tpt_pkg::PA_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  input wire logic page_fault_exception
);
  import tpt_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------
  // fetch count within one walk
  // ------
  logic [1:0] fetch_r;
  logic [1:0] fetch_nxt;
  always_comb begin
    fetch_nxt = fetch_r;
    if (!mem_req)
      fetch_nxt = 2'd0;
    else if (mem_ack && fetch_r != 2'd3)
      fetch_nxt = fetch_r + 2'd1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fetch_r <= 2'd0;
    else
      fetch_r <= fetch_nxt;
  end
  // ------
  // properties
  // ------
  sequence acc_first;
    psel && !penable ##1 psel && penable;
  endsequence
  ready_timing_a: assert property (acc_first |=> pready) else $error("pready late");
  ready_single_a: assert property (pready |=> !pready) else $error("pready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fetch request dropped or moved");
  next_level_a: assert property (mem_ack |=> !mem_req || mem_addr != $past(mem_addr))
    else $error("same entry fetched twice");
  entry_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
    else $error("entry address unaligned");
  fetch_bound_a: assert property (mem_req |-> fetch_r != 2'd3)
    else $error("walk deeper than three levels");
  fault_pulse_a: assert property (page_fault_exception |=> !page_fault_exception)
    else $error("fault held");
  fault_cause_a: assert property ($rose(page_fault_exception) |->
    $past(mem_ack) && !$past(mem_rdata[PRESENT_BIT])) else $error("fault without cause");
  fault_stop_a: assert property (page_fault_exception |-> !mem_req)
    else $error("fetch after fault");
endmodule
bind tpt_translator tpt_translator_monitor tpt_translator_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .page_fault_exception(page_fault_exception)
);

// ==== testbench/tpt_mem_model.sv ====
// tpt_mem_model: memory holding the paging tables, answering entry reads.
// assumes one read outstanding, held by the translator until acknowledged.
`timescale 1ns/1ps
module tpt_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic [tpt_pkg::PA_W-1:0] mem_addr,
  input wire logic [3:0] lag,
  output logic mem_ack,
  output logic [63:0] mem_rdata
);
  import tpt_pkg::*;
  logic [63:0] store [logic [PA_W-1:0]];
  logic [3:0] wait_r;
  int reads = 0;
  // tables stay resident all run; absent entries read as not present
  task automatic put(input logic [PA_W-1:0] a, input logic [63:0] d);
    store[a] = d;
  endtask
  // data lines toggle outside the ack cycle so stale data never looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= '0;
      wait_r <= '0;
    end else if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_r <= '0;
    end else if (wait_r == lag) begin
      mem_ack <= 1'b1;
      mem_rdata <= store.exists(mem_addr) ? store[mem_addr] : 64'h0;
      reads++;
    end else begin
      wait_r <= wait_r + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ==== testbench/tb_tpt_translator.sv ====
// tb_tpt_translator: self-checking bench for the page translator.
// assumes tpt_mem_model holds the tables and the monitor is bound in.
`timescale 1ns/1ps
module tb_tpt_translator;
  import tpt_pkg::*;
  localparam logic [31:0] DB = 32'h0001_0000;
  localparam logic [31:0] DBX = 32'h0002_0040;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mem_req;
  logic [PA_W-1:0] mem_addr;
  logic mem_ack;
  logic [63:0] mem_rdata;
  logic page_fault_exception;
  logic [3:0] lag = 4'h0;
  int fail_count = 0;
  int cmp_count = 0;
  int pf_n = 0;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (page_fault_exception === 1'b1) pf_n++;
  tpt_translator tpt_translator_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .page_fault_exception(page_fault_exception)
  );
  tpt_mem_model tpt_mem_model_i (
    .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .lag(lag), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );
  // ------
  // shared tasks
  // ------
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // st is {large, hit, fault}; nrd is the number of entry reads expected
  task automatic xlate(input logic [31:0] l, input logic [35:0] pa, input logic [2:0] st,
                       input int nrd);
    logic [31:0] q;
    logic e;
    int n0;
    int k;
    n0 = tpt_mem_model_i.reads;
    k = 0;
    apb(1'b1, OFS_LIN, l, q, e);
    do begin
      apb(1'b0, OFS_STATUS, 32'h0, q, e);
      k++;
    end while (q[ST_DONE_BIT] !== 1'b1 && k < 40);
    chk(36'(q[4:0]), 36'({st, 2'b10}));
    chk(36'(tpt_mem_model_i.reads - n0), 36'(nrd));
    if (!st[0]) begin
      apb(1'b0, OFS_PHYS_LO, 32'h0, q, e);
      chk(36'(q), 36'(pa[31:0]));
      apb(1'b0, OFS_PHYS_HI, 32'h0, q, e);
      chk(36'(q[3:0]), 36'(pa[35:32]));
    end
  endtask
  task automatic end_sim;
    $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_reset;
    logic [7:0] ofs [5] = '{OFS_PRIMARY, OFS_DIRBASE, OFS_EXT, OFS_PHYS_LO, OFS_STATUS};
    logic [31:0] q;
    logic e;
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0, q, e);
      chk(36'(q), 36'(RST_REG));
    end
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk(36'(e), 36'h1);
  endtask
  task automatic t_small;
    logic [31:0] q;
    logic e;
    logic [31:0] l;
    l = 32'hFFFF_F123;
    tpt_mem_model_i.put({4'h0, DB[31:12], l[31:22], 2'b00}, 64'h0003_0081);
    tpt_mem_model_i.put({4'h0, 20'h0_0030, l[21:12], 2'b00}, 64'hFFFF_FFFF_89AB_C001);
    apb(1'b1, OFS_DIRBASE, DB, q, e);
    apb(1'b1, OFS_PRIMARY, 32'h7FFF_FFFF, q, e);
    xlate(l, {4'h0, l}, 3'b000, 0);
    apb(1'b1, OFS_PRIMARY, 32'h8000_0000, q, e);
    xlate(l, 36'h0_89AB_C123, 3'b000, 2);
    xlate(l, 36'h0_89AB_C123, 3'b010, 0);
  endtask
  task automatic t_large;
    logic [31:0] q;
    logic e;
    logic [31:0] l;
    logic [31:0] m;
    logic [31:0] d;
    l = 32'hFFFF_F123;
    m = 32'h0040_2ABC;
    d = 32'h0003_0081;
    tpt_mem_model_i.put({4'h0, DB[31:12], m[31:22], 2'b00}, 64'h0004_0001);
    tpt_mem_model_i.put({4'h0, 20'h0_0040, m[21:12], 2'b00}, 64'h1234_5001);
    // caches are emptied on this write, as old sizes would be stale
    apb(1'b1, OFS_EXT, 32'h0000_0010, q, e);
    xlate(l, {d[16:13], d[31:22], l[21:0]}, 3'b100, 1);
    xlate(m, {4'h0, 20'h1_2345, m[11:0]}, 3'b000, 2);
    xlate(l, {d[16:13], d[31:22], l[21:0]}, 3'b110, 0);
    xlate(m, {4'h0, 20'h1_2345, m[11:0]}, 3'b010, 0);
  endtask
  task automatic t_fault;
    int pf0;
    pf0 = pf_n;
    xlate(32'h0080_0000, 36'h0, 3'b001, 1);
    chk(36'(pf_n - pf0), 36'h1);
  endtask
  task automatic t_ext;
    logic [31:0] q;
    logic e;
    logic [31:0] l;
    logic [31:0] m;
    logic [63:0] p;
    logic [63:0] d;
    logic [63:0] t;
    l = 32'hC060_3456;
    m = 32'h4020_0ABC;
    p = 64'h0000_0005_0000_0001;
    d = 64'h0000_0006_0000_0001;
    t = 64'h0000_0007_8900_0001;
    lag <= 4'h3;
    tpt_mem_model_i.put({4'h0, DBX[31:5], l[31:30], 3'b000}, p);
    tpt_mem_model_i.put({p[35:12], l[29:21], 3'b000}, d);
    tpt_mem_model_i.put({d[35:12], l[20:12], 3'b000}, t);
    p = 64'h0000_0005_1000_0001;
    d = 64'h0000_000A_BCE0_0081;
    tpt_mem_model_i.put({4'h0, DBX[31:5], m[31:30], 3'b000}, p);
    tpt_mem_model_i.put({p[35:12], m[29:21], 3'b000}, d);
    apb(1'b1, OFS_EXT, 32'h0000_0020, q, e);
    apb(1'b1, OFS_DIRBASE, DBX, q, e);
    xlate(l, {t[35:12], l[11:0]}, 3'b000, 3);
    xlate(m, {d[35:21], m[20:0]}, 3'b100, 2);
    // a flush must force the large walk again instead of a hit
    apb(1'b1, OFS_FLUSH, 32'h0, q, e);
    xlate(m, {d[35:21], m[20:0]}, 3'b100, 2);
  endtask
  task automatic t_misc;
    logic [31:0] q;
    logic e;
    int pf0;
    pf0 = pf_n;
    // pointer slot 0 and table slot 4 are never written, so both read as absent
    xlate(32'h0000_1000, 36'h0, 3'b001, 1);
    xlate(32'hC060_4456, 36'h0, 3'b001, 3);
    chk(36'(pf_n - pf0), 36'h2);
    apb(1'b1, OFS_STATUS, 32'h0000_0006, q, e);
    apb(1'b0, OFS_STATUS, 32'h0, q, e);
    chk(36'(q[4:0]), 36'h0);
    // reset in mid-run must drop the extension control setting, the only one read back here
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_EXT, 32'h0, q, e);
    chk(36'(q), 36'(RST_REG));
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    chk(36'({pready, pslverr, mem_req, page_fault_exception}), 36'h0);
    presetn <= 1'b1;
    t_reset;
    t_small;
    t_large;
    t_fault;
    t_ext;
    t_misc;
    end_sim;
  end
  // whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_sim;
  end
endmodule
